// ==== design/btn_debounce.sv ====
// Synchroniser and debouncer for one panel button
`timescale 1ns/100ps
`default_nettype none
module btn_debounce
  import hipot_pkg::*;
#(
  parameter logic [DB_W-1:0] DB_TICKS = DB_W'(DB_MS)
) (
  // Clock and reset
  input  wire logic CLK_I,
  input  wire logic RST_I,
  // Button
  btn_if.deb        btn
);

  typedef struct packed {
    logic            sync1;
    logic            sync2;
    logic            stable;
    logic [DB_W-1:0] cnt;
    logic            press;
  } deb_s;

  deb_s s_q;
  deb_s s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.press = 1'b0;
    s_d.sync1 = btn.raw;
    s_d.sync2 = s_q.sync1;
    if (s_q.sync2 == s_q.stable) begin
      s_d.cnt = '0;
    end else if (btn.tick) begin
      if (s_q.cnt == DB_TICKS - 1'b1) begin
        s_d.cnt    = '0;
        s_d.stable = s_q.sync2;
        s_d.press  = s_q.sync2;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign btn.press = s_q.press;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_press_single: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_q.press |=> !s_q.press) else $error("press lasted two cycles");

endmodule : btn_debounce
`default_nettype wire

// ==== design/btn_if.sv ====
// Button debounce connection between sequencer and debouncer
`timescale 1ns/100ps
`default_nettype none
interface btn_if;
  logic tick;
  logic raw;
  logic press;
  modport deb (input tick, input raw, output press);
  modport seq (output tick, output raw, input press);
endinterface : btn_if
`default_nettype wire

// ==== design/hipot_pkg.sv ====
// Constants, types and register map of the hipot test control sequencer
//
// Overview of operation
// - Over-current fail holds lamp and alarm until reset
// - Ground fault latches fail, ready lamp off
// - Under-current fail tone one second, then self-reset
// - Two-palm fail signal two seconds, then self-reset
// - Ohm-sense fail beeps until reset, no lamps
// - Optional tone beeps during test, not failure
// - Ready lamp and test only with ground good
// - Start from panel, remote or two-palm source
// - Test start enables high voltage, testing lamp
// - Testing lamp off when dwell time elapses
// - Over-current, ground loss or arc aborts, latches fail
// - High voltage stops whenever a test finishes
// - Latched fail refuses new test until reset
// - Reset clears latched or ohm-sense fail and alarm, ready returns; timed fails ignore it
// - Dwell time adjustable one to ninety seconds
// - High voltage removed within two milliseconds
package hipot_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned TICK_NS        = 1_000_000;
  localparam int unsigned TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = 18;
  localparam int unsigned MS_W           = 17;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned UNDER_FAIL_MS  = 1000;
  localparam int unsigned PALM_FAIL_MS   = 2000;
  localparam int unsigned OHM_HALF_MS    = 320;
  localparam int unsigned TONE_HALF_MS   = 100;
  localparam int unsigned BEEP_W         = 9;
  localparam int unsigned DB_MS          = 10;
  localparam int unsigned DB_W           = 4;
  localparam int unsigned HV_OFF_MAX_NS  = 2_000_000;

  // ----------------------------------------------------------------
  // Register map (byte offsets, word index in bits 3:2)
  // ----------------------------------------------------------------
  localparam logic [1:0] IDX_CTRL  = 2'h0;
  localparam logic [1:0] IDX_STAT  = 2'h1;
  localparam logic [1:0] IDX_IRQ   = 2'h2;
  localparam logic [1:0] IDX_MASK  = 2'h3;
  localparam int unsigned DWELL_W     = 7;
  localparam int unsigned CTRL_TONE   = 8;
  localparam int unsigned CTRL_FINE   = 9;
  localparam logic [6:0] DWELL_MIN_S = 7'h01;
  localparam logic [6:0] DWELL_MAX_S = 7'h5a;
  localparam logic [6:0] DWELL_RST_S = 7'h3c;
  localparam int unsigned STAT_GND    = 5;
  localparam int unsigned STAT_GFLT   = 6;
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_PASS    = 0;
  localparam int unsigned IRQ_LATCH   = 1;
  localparam int unsigned IRQ_TIMED   = 2;
  localparam int unsigned IRQ_OHM     = 3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_TEST  = 5'h02,
    S_LATCH = 5'h04,
    S_TIMED = 5'h08,
    S_OHM   = 5'h10
  } state_e;

endpackage : hipot_pkg

// ==== design/hipot_sequencer.sv ====
// Hipot test control sequencer with Wishbone register slave
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module hipot_sequencer
  import hipot_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Wishbone slave
  input  wire logic [3:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  output var  logic [31:0] DAT_O,
  input  wire logic        WE_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output var  logic        ACK_O,
  output var  logic        INT_O,
  // Start and reset sources
  input  wire logic        START_BTN_I,
  input  wire logic        RESET_BTN_I,
  input  wire logic        REM_START_I,
  input  wire logic        REM_RESET_I,
  input  wire logic        PALM_START_I,
  // Sense and trip inputs
  input  wire logic        GND_OK_I,
  input  wire logic        OVER_CUR_I,
  input  wire logic        UNDER_CUR_I,
  input  wire logic        ARC_I,
  input  wire logic        PALM_FAIL_I,
  input  wire logic        OHM_FAIL_I,
  // Lamps, alarm, high voltage and ground fine output
  output var  logic        READY_LAMP_O,
  output var  logic        TEST_LAMP_O,
  output var  logic        FAIL_LAMP_O,
  output var  logic        ALARM_O,
  output var  logic        HV_ON_O,
  output var  logic        GND_FINE_O
);

  typedef struct packed {
    state_e             state;
    logic [TICK_W-1:0]  tick_cnt;
    logic [MS_W-1:0]    ms_cnt;
    logic [BEEP_W-1:0]  beep_cnt;
    logic               beep;
    logic               timed_long;
    logic               gnd_fault;
    logic [DWELL_W-1:0] dwell;
    logic               tone_en;
    logic               gnd_fine;
    logic [IRQ_W-1:0]   irq;
    logic [IRQ_W-1:0]   mask;
    logic               ack;
    logic [31:0]        dat;
    logic               rem_start;
    logic               rem_reset;
    logic               palm_start;
  } seq_s;

  seq_s s_q;
  seq_s s_d;

  logic            tick;
  logic            start_ev;
  logic            reset_ev;
  logic            fault;
  logic            req;
  logic [MS_W-1:0] dwell_ms;
  logic [MS_W-1:0] timed_ms;
  logic [BEEP_W-1:0] half_ms;
  logic [6:0]      wdwell;

  btn_if start_btn ();
  btn_if reset_btn ();

  // ----------------------------------------------------------------
  // Button debouncers
  // ----------------------------------------------------------------
  assign start_btn.tick = tick;
  assign start_btn.raw  = START_BTN_I;
  assign reset_btn.tick = tick;
  assign reset_btn.raw  = RESET_BTN_I;

  btn_debounce u_start_db (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .btn   (start_btn.deb)
  );

  btn_debounce u_reset_db (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .btn   (reset_btn.deb)
  );

  // ----------------------------------------------------------------
  // Events and limits
  // ----------------------------------------------------------------
  assign tick     = (s_q.tick_cnt == TICK_W'(TICK_CYCLES - 1));
  assign start_ev = start_btn.press | (REM_START_I & ~s_q.rem_start)
                  | (PALM_START_I & ~s_q.palm_start);
  assign reset_ev = reset_btn.press | (REM_RESET_I & ~s_q.rem_reset);
  assign fault    = OVER_CUR_I | ARC_I | ~GND_OK_I;
  assign dwell_ms = MS_W'(s_q.dwell * MS_W'(MS_PER_S));
  assign timed_ms = s_q.timed_long ? MS_W'(PALM_FAIL_MS)
                                   : MS_W'(UNDER_FAIL_MS);
  assign half_ms  = (s_q.state == S_OHM) ? BEEP_W'(OHM_HALF_MS)
                                         : BEEP_W'(TONE_HALF_MS);
  assign req      = CYC_I & STB_I & ~s_q.ack;
  assign wdwell   = DAT_I[DWELL_W-1:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.ack        = 1'b0;
    s_d.rem_start  = REM_START_I;
    s_d.rem_reset  = REM_RESET_I;
    s_d.palm_start = PALM_START_I;
    s_d.tick_cnt   = tick ? '0 : s_q.tick_cnt + 1'b1;

    // Register access
    if (req) begin
      s_d.ack = 1'b1;
      s_d.dat = '0;
      if (WE_I) begin
        if (ADR_I[3:2] == IDX_CTRL && SEL_I[0]) begin
          if (wdwell < DWELL_MIN_S) begin
            s_d.dwell = DWELL_MIN_S;
          end else if (wdwell > DWELL_MAX_S) begin
            s_d.dwell = DWELL_MAX_S;
          end else begin
            s_d.dwell = wdwell;
          end
        end
        if (ADR_I[3:2] == IDX_CTRL && SEL_I[1]) begin
          s_d.tone_en  = DAT_I[CTRL_TONE];
          s_d.gnd_fine = DAT_I[CTRL_FINE];
        end
        if (ADR_I[3:2] == IDX_MASK && SEL_I[0]) begin
          s_d.mask = DAT_I[IRQ_W-1:0];
        end
      end else begin
        case (ADR_I[3:2])
          IDX_CTRL: begin
            s_d.dat[DWELL_W-1:0] = s_q.dwell;
            s_d.dat[CTRL_TONE]   = s_q.tone_en;
            s_d.dat[CTRL_FINE]   = s_q.gnd_fine;
          end
          IDX_STAT: begin
            s_d.dat[4:0]       = s_q.state;
            s_d.dat[STAT_GND]  = GND_OK_I;
            s_d.dat[STAT_GFLT] = s_q.gnd_fault;
          end
          IDX_IRQ: begin
            s_d.dat[IRQ_W-1:0] = s_q.irq;
            s_d.irq            = '0;
          end
          IDX_MASK: begin
            s_d.dat[IRQ_W-1:0] = s_q.mask;
          end
          default: begin
            s_d.dat = '0;
          end
        endcase
      end
    end

    // Timers
    if (tick) begin
      s_d.ms_cnt = s_q.ms_cnt + 1'b1;
      if (s_q.beep_cnt == half_ms - 1'b1) begin
        s_d.beep_cnt = '0;
        s_d.beep     = ~s_q.beep;
      end else begin
        s_d.beep_cnt = s_q.beep_cnt + 1'b1;
      end
    end

    // Sequencer
    case (s_q.state)
      S_IDLE: begin
        if (OHM_FAIL_I) begin
          s_d.state          = S_OHM;
          s_d.irq[IRQ_OHM]   = 1'b1;
        end else if (PALM_FAIL_I) begin
          s_d.state          = S_TIMED;
          s_d.timed_long     = 1'b1;
          s_d.irq[IRQ_TIMED] = 1'b1;
        end else if (start_ev && GND_OK_I) begin
          s_d.state = S_TEST;
        end
      end
      S_TEST: begin
        if (reset_ev) begin
          s_d.state          = S_IDLE;
        end else if (fault) begin
          s_d.state          = S_LATCH;
          s_d.gnd_fault      = ~GND_OK_I;
          s_d.irq[IRQ_LATCH] = 1'b1;
        end else if (OHM_FAIL_I) begin
          s_d.state          = S_OHM;
          s_d.irq[IRQ_OHM]   = 1'b1;
        end else if (PALM_FAIL_I) begin
          s_d.state          = S_TIMED;
          s_d.timed_long     = 1'b1;
          s_d.irq[IRQ_TIMED] = 1'b1;
        end else if (UNDER_CUR_I) begin
          s_d.state          = S_TIMED;
          s_d.timed_long     = 1'b0;
          s_d.irq[IRQ_TIMED] = 1'b1;
        end else if (tick && s_q.ms_cnt == dwell_ms - 1'b1) begin
          s_d.state          = S_IDLE;
          s_d.irq[IRQ_PASS]  = 1'b1;
        end
      end
      S_LATCH: begin
        if (reset_ev) begin
          s_d.state     = S_IDLE;
          s_d.gnd_fault = 1'b0;
        end
      end
      S_TIMED: begin
        if (tick && s_q.ms_cnt == timed_ms - 1'b1) begin
          s_d.state = S_IDLE;
        end
      end
      S_OHM: begin
        if (reset_ev) begin
          s_d.state = S_IDLE;
        end
      end
      default: begin
        s_d.state = S_IDLE;
      end
    endcase

    if (s_d.state != s_q.state) begin
      s_d.ms_cnt   = '0;
      s_d.beep_cnt = '0;
      s_d.beep     = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q       <= '0;
      s_q.state <= S_IDLE;
      s_q.dwell <= DWELL_RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ACK_O        = s_q.ack;
  assign DAT_O        = s_q.dat;
  assign INT_O        = |(s_q.irq & s_q.mask);
  assign GND_FINE_O   = s_q.gnd_fine;
  assign READY_LAMP_O = GND_OK_I & ((s_q.state == S_IDLE)
                      | ((s_q.state == S_LATCH) & ~s_q.gnd_fault));
  assign TEST_LAMP_O  = (s_q.state == S_TEST);
  assign HV_ON_O      = (s_q.state == S_TEST);
  assign FAIL_LAMP_O  = (s_q.state == S_LATCH) | (s_q.state == S_TIMED);
  assign ALARM_O      = FAIL_LAMP_O | ((s_q.state == S_OHM) & s_q.beep)
                      | (TEST_LAMP_O & s_q.tone_en & s_q.beep);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_hv_abort: assert property (HV_ON_O && fault && !reset_ev
    |=> !HV_ON_O && FAIL_LAMP_O && ALARM_O) else $error("fault not aborted");
  a_hv_off_fast: assert property (HV_ON_O && (fault || reset_ev)
    |=> !HV_ON_O) else $error("voltage outlived test");
  a_latch_hold: assert property (s_q.state == S_LATCH && !reset_ev
    |=> FAIL_LAMP_O && ALARM_O) else $error("latched fail dropped");
  a_gnd_ready: assert property (s_q.gnd_fault |-> !READY_LAMP_O)
    else $error("ready lamp on after ground fault");
  a_ready_gnd: assert property (READY_LAMP_O |-> GND_OK_I)
    else $error("ready lamp without ground");
  a_start_test: assert property (s_q.state == S_IDLE && start_ev
    && GND_OK_I && !OHM_FAIL_I && !PALM_FAIL_I
    |=> TEST_LAMP_O && HV_ON_O) else $error("start not taken");
  a_refuse_start: assert property (s_q.state == S_LATCH && !reset_ev
    |=> !HV_ON_O) else $error("test started from latched fail");
  a_reset_clear: assert property (s_q.state == S_LATCH && reset_ev
    |=> !FAIL_LAMP_O ##0 !ALARM_O) else $error("reset left fail on");
  a_ohm_lamps: assert property (s_q.state == S_OHM
    |-> !TEST_LAMP_O && !FAIL_LAMP_O) else $error("lamp lit in ohm fail");
  a_tone_quiet: assert property (TEST_LAMP_O && !s_q.tone_en
    |-> !ALARM_O) else $error("alarm during test without tone");
  a_timed_len: assert property (s_q.state == S_TIMED
    |-> s_q.ms_cnt < timed_ms) else $error("timed fail overran");
  a_dwell_end: assert property (TEST_LAMP_O && !fault && !reset_ev
    && !OHM_FAIL_I && !PALM_FAIL_I && !UNDER_CUR_I && tick
    && s_q.ms_cnt == dwell_ms - 1'b1 |=> !TEST_LAMP_O && !HV_ON_O)
    else $error("test ran past dwell");
  a_dwell_range: assert property (s_q.dwell >= DWELL_MIN_S
    && s_q.dwell <= DWELL_MAX_S) else $error("dwell out of range");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");

  c_pass: cover property (TEST_LAMP_O ##1 s_q.irq[IRQ_PASS]);
  c_latch: cover property (s_q.state == S_LATCH ##[1:20] s_q.state == S_IDLE);
  c_timed: cover property ($rose(s_q.state == S_TIMED));
  c_ohm: cover property (s_q.state == S_OHM && ALARM_O);

endmodule : hipot_sequencer
`default_nettype wire

// ==== verification/panel_model.sv ====
// Operator panel and remote interface model driving start and reset
`timescale 1ns/100ps
`default_nettype none
module panel_model #(
  parameter int GAP = 40
) (
  // Clock
  input  wire logic clk_i,
  // Start and reset sources
  output var  logic start_btn_o,
  output var  logic reset_btn_o,
  output var  logic rem_start_o,
  output var  logic rem_reset_o,
  output var  logic palm_start_o
);
  int cyc_n = 0;
  int st_n  = 0;

  initial begin
    {start_btn_o, reset_btn_o, rem_start_o, rem_reset_o} = 4'h0;
    palm_start_o = 1'b0;
  end

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
  end

  task automatic wait_gap();
    while (cyc_n - st_n < GAP) @(posedge clk_i);
    st_n = cyc_n;
  endtask : wait_gap

  // One-cycle remote or palm event: 0 start, 1 reset, 2 palm start
  task automatic pulse(input int k);
    if (k != 1) wait_gap();
    @(posedge clk_i);
    case (k)
      0:       rem_start_o <= 1'b1;
      1:       rem_reset_o <= 1'b1;
      default: palm_start_o <= 1'b1;
    endcase
    @(posedge clk_i);
    {rem_start_o, rem_reset_o, palm_start_o} <= 3'h0;
  endtask : pulse

  // Bouncing panel press: 0 start, 1 reset
  task automatic press(input int k, input int hold);
    if (k == 0) wait_gap();
    for (int i = 0; i < 6 + hold; i++) begin
      @(posedge clk_i);
      if (k == 0) start_btn_o <= (i >= 6) || i[0];
      else reset_btn_o <= (i >= 6) || i[0];
    end
    @(posedge clk_i);
    start_btn_o <= 1'b0;
    reset_btn_o <= 1'b0;
  endtask : press
endmodule : panel_model
`default_nettype wire

// ==== verification/tb_hipot_test_control_sequencer.sv ====
// Self-checking bench for the hipot test control sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_hipot_test_control_sequencer
  import hipot_pkg::*;
;
  localparam int TK = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        gnd = 1'b1;
  logic        ovr = 1'b0;
  logic        und = 1'b0;
  logic        arc = 1'b0;
  logic        pfl = 1'b0;
  logic        ohm = 1'b0;
  logic        sb, rb, rs, rr, ps, ack, irq, rdy, tst, fl, alm, hv, fine;
  logic [31:0] dato, q, d, ce;
  logic [3:0]  ws = 4'hf;
  logic [15:0] lf = 16'h4001;
  logic [15:0] dw [4] = '{16'h0, 16'h7f, 16'h15a, 16'h301};
  int          bad_count = 0;
  int          n_tests = 0;
  int          cy = 0;
  int          n, t0;

  always #2 clk = ~clk;
  always @(posedge clk) cy <= cy + 1;

  hipot_sequencer #(.TICK_CYCLES(TK)) i_hipot_sequencer (
    .CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat), .DAT_O(dato),
    .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
    .INT_O(irq), .START_BTN_I(sb), .RESET_BTN_I(rb), .REM_START_I(rs),
    .REM_RESET_I(rr), .PALM_START_I(ps), .GND_OK_I(gnd),
    .OVER_CUR_I(ovr), .UNDER_CUR_I(und), .ARC_I(arc),
    .PALM_FAIL_I(pfl), .OHM_FAIL_I(ohm), .READY_LAMP_O(rdy),
    .TEST_LAMP_O(tst), .FAIL_LAMP_O(fl), .ALARM_O(alm), .HV_ON_O(hv),
    .GND_FINE_O(fine));

  panel_model #(.GAP(40)) i_panel_model (
    .clk_i(clk), .start_btn_o(sb), .reset_btn_o(rb), .rem_start_o(rs),
    .rem_reset_o(rr), .palm_start_o(ps));

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx

  function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
    logic [6:0] s;
    s = v[6:0] < DWELL_MIN_S ? DWELL_MIN_S :
        v[6:0] > DWELL_MAX_S ? DWELL_MAX_S : v[6:0];
    return {22'h0, v[9:8], 1'b0, s};
  endfunction : ctrl_exp

  function automatic logic [31:0] near(input int v, input int e);
    return 32'(v >= e - TK - 2 && v <= e + TK + 2);
  endfunction : near

  function automatic logic sig(input int s);
    case (s)
      0:       return tst;
      1:       return fl;
      default: return alm;
    endcase
  endfunction : sig

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step

  task automatic dur(input int s, input logic v, output int c);
    c = 0;
    while (sig(s) === v && c < 40000) begin
      step(1);
      c++;
    end
  endtask : dur

  task automatic wb(input logic w, input logic [1:0] i, input logic [31:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, lf[1:0]};
    dat <= v;
    sel <= w ? ws : lf[3:0];
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chk("lamps", {rdy, tst, fl, alm, hv}, 32'h10);
    wb(0, IDX_CTRL, 0);
    chk("ctrl", q, 32'(DWELL_RST_S));
    wb(0, IDX_MASK, 0);
    chk("mask", q, 0);
    wb(0, IDX_STAT, 0);
    chk("stat", q, 32'(S_IDLE) | 32'h20);
    ce = 32'(DWELL_RST_S);
    foreach (dw[i]) begin
      lf = nx(lf);
      d = {lf, dw[i]};
      ws = lf[3:0];
      wb(1, IDX_CTRL, d);
      q = ctrl_exp(d);
      if (ws[0]) ce[6:0] = q[6:0];
      if (ws[1]) ce[9:8] = q[9:8];
      wb(0, IDX_CTRL, 0);
      chk("ctrl", q, ce);
    end
    ws = 4'hf;
    wb(1, IDX_CTRL, 32'h301);
    wb(0, IDX_CTRL, 0);
    chk("ctrl", q, 32'h301);
    chk("fine", fine, 1);
    wb(1, IDX_MASK, 32'hf);
    // Trips ignored while idle, ready follows ground
    repeat (8) begin
      lf = nx(lf);
      @(posedge clk);
      {ovr, arc, und, gnd} <= lf[3:0];
      step(1);
      chk("idle trips", {tst, fl, alm, hv, rdy}, 32'(gnd));
    end
    @(posedge clk);
    {ovr, arc, und, gnd} <= 4'h1;
    // Remote start, tone and dwell expiry
    i_panel_model.pulse(0);
    t0 = cy;
    step(0);
    chk("test on", {tst, hv, rdy}, 32'h6);
    dur(2, alm, n);
    dur(2, alm, n);
    chk("tone", near(n, TONE_HALF_MS * TK), 1);
    dur(0, 1'b1, n);
    chk("dwell", near(cy - t0, MS_PER_S * TK), 1);
    chk("pass", {tst, hv, fl, alm, rdy, irq}, 32'h3);
    wb(0, IDX_IRQ, 0);
    chk("irq pass", q, 32'h1);
    chk("int", irq, 0);
    // Panel start, over-current at a random point
    i_panel_model.press(0, 150);
    step(0);
    chk("btn start", tst, 1);
    lf = nx(lf);
    repeat (lf[7:0] + 8) @(posedge clk);
    ovr <= 1'b1;
    step(1);
    chk("over", {tst, hv, fl, alm, rdy}, 32'h7);
    @(posedge clk);
    ovr <= 1'b0;
    i_panel_model.pulse(0);
    step(3);
    chk("refused", {tst, fl}, 32'h1);
    i_panel_model.press(1, 150);
    step(0);
    chk("btn reset", {fl, alm, rdy}, 32'h1);
    // Ground loss during a test
    i_panel_model.pulse(0);
    @(posedge clk);
    gnd <= 1'b0;
    step(1);
    chk("gnd fault", {tst, hv, fl, alm, rdy}, 32'h6);
    @(posedge clk);
    gnd <= 1'b1;
    step(1);
    chk("gnd held", {fl, rdy}, 32'h2);
    wb(0, IDX_STAT, 0);
    chk("stat", q, 32'(S_LATCH) | 32'h60);
    i_panel_model.pulse(1);
    step(0);
    chk("gnd reset", {fl, alm, rdy}, 32'h1);
    @(posedge clk);
    gnd <= 1'b0;
    i_panel_model.pulse(0);
    step(2);
    chk("no ground", {tst, rdy}, 0);
    @(posedge clk);
    gnd <= 1'b1;
    // Palm start, then arc
    i_panel_model.pulse(2);
    step(0);
    chk("palm start", tst, 1);
    @(posedge clk);
    arc <= 1'b1;
    step(1);
    chk("arc", {hv, fl}, 32'h1);
    @(posedge clk);
    arc <= 1'b0;
    i_panel_model.pulse(1);
    wb(0, IDX_IRQ, 0);
    chk("irq latch", q, 32'h2);
    // Timed fails with their interrupt masked
    wb(1, IDX_MASK, 32'h1);
    for (int k = 0; k < 2; k++) begin
      i_panel_model.pulse(0);
      @(posedge clk);
      und <= k == 0;
      pfl <= k == 1;
      step(1);
      t0 = cy;
      chk("timed", {tst, hv, fl, alm}, 32'h3);
      @(posedge clk);
      und <= 1'b0;
      pfl <= 1'b0;
      dur(1, 1'b1, n);
      n = k ? PALM_FAIL_MS * TK : UNDER_FAIL_MS * TK;
      chk("timed len", near(cy - t0, n), 1);
      chk("self reset", {fl, alm, rdy, irq}, 32'h2);
      wb(0, IDX_IRQ, 0);
      chk("irq timed", q, 32'h4);
    end
    // Ohm-sense fail beeps without lamps
    @(posedge clk);
    ohm <= 1'b1;
    step(1);
    chk("ohm", {tst, fl}, 0);
    dur(2, alm, n);
    dur(2, alm, n);
    chk("ohm beep", near(n, OHM_HALF_MS * TK), 1);
    @(posedge clk);
    ohm <= 1'b0;
    i_panel_model.pulse(1);
    step(0);
    chk("ohm reset", {alm, fl, tst}, 0);
    wb(1, IDX_MASK, 32'h8);
    chk("int ohm", irq, 1);
    wb(0, IDX_IRQ, 0);
    chk("irq ohm", q, 32'h8);
    step(1);
    chk("int clr", irq, 0);
    finish_test();
  end
endmodule : tb_hipot_test_control_sequencer
`default_nettype wire
